// >>> lfm_consts.svh
// Constants for the LED driver fault monitor: offsets, fields, timing
// Assumes a 40 MHz pclk and a 32-bit APB register bus
`ifndef LFM_CONSTS_SVH
`define LFM_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define LFM_OFS_CTRL      12'h000
`define LFM_OFS_CFG       12'h004
`define LFM_OFS_DIAGEN    12'h008
`define LFM_OFS_FLAGS     12'h00c
`define LFM_OFS_OPENFLG   12'h010
`define LFM_OFS_SHORTFLG  12'h014
`define LFM_OFS_SUPPLY    12'h018
`define LFM_OFS_STATUS    12'h01c

// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define LFM_CTRL_CLR_BIT  0
`define LFM_CFG_TH_LSB    0
`define LFM_CFG_WD_LSB    8
`define LFM_CFG_DLY_LSB   12
`define LFM_CFG_MSK_LSB   16
`define LFM_CFG_RST       32'h0000_0000
`define LFM_DIAGEN_RST    12'hfff

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LFM_CLK_HZ        40000000
`define LFM_PULSE_US      50
`define LFM_PULSE_CYC     ((`LFM_CLK_HZ / 1000000) * `LFM_PULSE_US)
`define LFM_CONV_CYC      16'd400
`define LFM_DEG_CYC       16'd80
`define LFM_DLY_UNIT      16'd40
`define LFM_WD_UNIT       32'd40000
`define LFM_NCH           12

`endif

// >>> lfm_pkg.sv
// Types for the LED driver fault monitor
// Constants live in lfm_consts.svh
package lfm_pkg;
  typedef struct packed {
    logic low_supply;
    logic reference;
    logic prethermal;
    logic tshutdown;
    logic out_any;
    logic error;
  } lfm_flags_t;

  typedef struct packed {
    logic mask_open;
    logic mask_short;
    logic mask_ref;
    logic mask_tsd;
  } lfm_mask_t;

  typedef enum logic [1:0] {
    LFM_NORMAL = 2'b00,
    LFM_FS0    = 2'b01,
    LFM_FS1    = 2'b11
  } lfm_mode_t;
endpackage : lfm_pkg

// >>> lfm_monitor.sv
// Fault supervision for a 12-channel LED driver with APB registers
// Assumes synchronous inputs; comparator/ADC results arrive as inputs
// Behaviour
// - Low supply: 50 us fault pulse, set flag
// - Clear bit resets flags, self-clears
// - Sample supply code every conversion cycle
// - Open diagnosis only at or above low-supply threshold; short diagnosis at any supply
// - Threshold code spans 5 V to 20 V
// - Reference fault: constant sink, set flags
// - Reference recovery: sink released, flags latched
// - Prethermal rise: 50 us pulse, latched flag
// - Overtemperature: outputs off, constant sink, flags
// - Cooling: outputs back, sink released, flag kept
// - Extreme temperature: full reset on recovery
// - Watchdog restarts on matching good frames only
// - Overflow picks fail-safe state by pin
// - Four-bit period; zero disables watchdog
// - Stored period all ones: enter fail-safe directly
// - Open monitor only in long enough on-time
// - Persistent open: pulse, channel/output/error flags
// - Short monitor only in long enough on-time
// - Persistent short: pulse, flags, no protection
// - Masks hide pin and error-flag reporting, reference/shutdown flags still set; disabled channels report nothing
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "lfm_consts.svh"

module lfm_monitor
  import lfm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  adc_supply_code,
  input  wire logic        ref_fault_in,
  input  wire logic        prethermal_in,
  input  wire logic        overtemp_in,
  input  wire logic        extreme_temp_in,
  input  wire logic        frame_ok,
  input  wire logic        frame_broadcast,
  input  wire logic        frame_addr_match,
  input  wire logic        failsafe_select_pin,
  input  wire logic [3:0]  stored_watchdog_period,
  input  wire logic [11:0] pwm_on,
  input  wire logic [11:0] open_cmp,
  input  wire logic [11:0] short_cmp,
  output logic             fault_pin_o,
  output logic             fault_pin_oe,
  output logic             outputs_enable,
  output logic [1:0]       failsafe_state
);

  // ----------------------------------------------------------------
  // Internal reset from extreme temperature
  // ----------------------------------------------------------------
  logic rst_n;
  assign rst_n = presetn & ~extreme_temp_in;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic        wr_en;
  logic        rd_en;
  logic [31:0] cfg_ff;
  logic [11:0] channel_diag_enable;
  logic        fault_clear_cmd;
  lfm_flags_t  flags_ff;
  logic [11:0] channel_open_flag;
  logic [11:0] channel_short_flag;
  logic [7:0]  supply_result_ff;
  lfm_mode_t   mode_ff;
  logic        low_supply;
  lfm_mask_t   mask;
  logic [7:0]  low_supply_threshold_code;
  logic [3:0]  link_watchdog_period;
  logic [3:0]  diag_pulse_delay_cfg;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction : hit

  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  assign low_supply_threshold_code = cfg_ff[`LFM_CFG_TH_LSB +: 8];
  assign link_watchdog_period = cfg_ff[`LFM_CFG_WD_LSB +: 4];
  assign diag_pulse_delay_cfg = cfg_ff[`LFM_CFG_DLY_LSB +: 4];
  assign mask = lfm_mask_t'(cfg_ff[`LFM_CFG_MSK_LSB +: 4]);

  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff              <= `LFM_CFG_RST;
      channel_diag_enable <= `LFM_DIAGEN_RST;
    end else if (wr_en) begin
      if (hit(paddr, `LFM_OFS_CFG)) begin
        cfg_ff <= pwdata;
      end
      if (hit(paddr, `LFM_OFS_DIAGEN)) begin
        channel_diag_enable <= pwdata[11:0];
      end
    end
  end

  // Clear command lasts one cycle, then returns to zero
  assign fault_clear_cmd = wr_en & hit(paddr, `LFM_OFS_CTRL)
                         & pwdata[`LFM_CTRL_CLR_BIT];

  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en & ~penable) begin
      case (paddr)
        `LFM_OFS_CFG:      prdata <= cfg_ff;
        `LFM_OFS_DIAGEN:   prdata <= {20'h0_0000, channel_diag_enable};
        `LFM_OFS_FLAGS:    prdata <= {26'h000_0000, flags_ff};
        `LFM_OFS_OPENFLG:  prdata <= {20'h0_0000, channel_open_flag};
        `LFM_OFS_SHORTFLG: prdata <= {20'h0_0000, channel_short_flag};
        `LFM_OFS_SUPPLY:   prdata <= {24'h00_0000, supply_result_ff};
        `LFM_OFS_STATUS:   prdata <= {28'h000_0000, mode_ff, low_supply,
                                      outputs_enable};
        default:           prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Supply conversion
  // ----------------------------------------------------------------
  logic [15:0] conv_cnt_ff;
  logic        conv_done;
  assign conv_done = (conv_cnt_ff == `LFM_CONV_CYC - 16'd1);

  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      conv_cnt_ff      <= 16'h0000;
      supply_result_ff <= 8'hff;
    end else if (conv_done) begin
      conv_cnt_ff      <= 16'h0000;
      supply_result_ff <= adc_supply_code;
    end else begin
      conv_cnt_ff <= conv_cnt_ff + 16'd1;
    end
  end

  assign low_supply = supply_result_ff < low_supply_threshold_code;

  // ----------------------------------------------------------------
  // Per-channel open and short deglitch
  // ----------------------------------------------------------------
  logic [15:0] deg_limit;
  logic [11:0] open_evt;
  logic [11:0] short_evt;
  assign deg_limit = 16'(diag_pulse_delay_cfg * `LFM_DLY_UNIT)
                   + `LFM_DEG_CYC;

  genvar g;
  generate
    for (g = 0; g < `LFM_NCH; g++) begin : g_ch
      logic [15:0] ocnt_ff;
      logic [15:0] scnt_ff;
      logic        odone_ff;
      logic        sdone_ff;
      always_ff @(posedge pclk or negedge rst_n) begin
        if (!rst_n) begin
          ocnt_ff  <= 16'h0000;
          odone_ff <= 1'b0;
        end else if (pwm_on[g] & open_cmp[g] & ~low_supply) begin
          if (ocnt_ff != deg_limit) begin
            ocnt_ff <= ocnt_ff + 16'd1;
          end
          odone_ff <= (ocnt_ff == deg_limit);
        end else begin
          ocnt_ff  <= 16'h0000;
          odone_ff <= 1'b0;
        end
      end
      always_ff @(posedge pclk or negedge rst_n) begin
        if (!rst_n) begin
          scnt_ff  <= 16'h0000;
          sdone_ff <= 1'b0;
        end else if (pwm_on[g] & short_cmp[g]) begin
          if (scnt_ff != deg_limit) begin
            scnt_ff <= scnt_ff + 16'd1;
          end
          sdone_ff <= (scnt_ff == deg_limit);
        end else begin
          scnt_ff  <= 16'h0000;
          sdone_ff <= 1'b0;
        end
      end
      // Report once per persistent fault, disabled channels silent
      assign open_evt[g]  = (ocnt_ff == deg_limit) & ~odone_ff
                          & pwm_on[g] & open_cmp[g] & ~low_supply
                          & channel_diag_enable[g];
      assign short_evt[g] = (scnt_ff == deg_limit) & ~sdone_ff
                          & pwm_on[g] & short_cmp[g]
                          & channel_diag_enable[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Events and flags
  // ----------------------------------------------------------------
  logic low_d_ff;
  logic pre_d_ff;
  logic low_evt;
  logic pre_evt;
  logic open_rep;
  logic short_rep;
  assign low_evt   = low_supply & ~low_d_ff;
  assign pre_evt   = prethermal_in & ~pre_d_ff;
  assign open_rep  = |open_evt & ~mask.mask_open;
  assign short_rep = |short_evt & ~mask.mask_short;

  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      low_d_ff <= 1'b0;
      pre_d_ff <= 1'b0;
    end else begin
      low_d_ff <= low_supply;
      pre_d_ff <= prethermal_in;
    end
  end

  // Set wins over clear
  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      flags_ff <= '0;
    end else begin
      flags_ff.low_supply <= low_evt
                           | (flags_ff.low_supply & ~fault_clear_cmd);
      flags_ff.reference  <= ref_fault_in
                           | (flags_ff.reference & ~fault_clear_cmd);
      flags_ff.prethermal <= pre_evt
                           | (flags_ff.prethermal & ~fault_clear_cmd);
      flags_ff.tshutdown  <= overtemp_in
                           | (flags_ff.tshutdown & ~fault_clear_cmd);
      flags_ff.out_any    <= open_rep | short_rep
                           | (flags_ff.out_any & ~fault_clear_cmd);
      flags_ff.error      <= (ref_fault_in & ~mask.mask_ref)
                           | (overtemp_in & ~mask.mask_tsd)
                           | open_rep | short_rep
                           | (flags_ff.error & ~fault_clear_cmd);
    end
  end

  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      channel_open_flag  <= 12'h000;
      channel_short_flag <= 12'h000;
    end else begin
      channel_open_flag  <= (open_evt & {12{~mask.mask_open}})
        | (channel_open_flag & {12{~fault_clear_cmd}});
      channel_short_flag <= (short_evt & {12{~mask.mask_short}})
        | (channel_short_flag & {12{~fault_clear_cmd}});
    end
  end

  // ----------------------------------------------------------------
  // Fault pin: pulse timer and constant sink
  // ----------------------------------------------------------------
  logic [15:0] pulse_cnt_ff;
  logic        pulse_evt;
  logic        const_sink;
  assign pulse_evt  = low_evt | pre_evt | open_rep | short_rep;
  assign const_sink = (ref_fault_in & ~mask.mask_ref)
                    | (overtemp_in & ~mask.mask_tsd);

  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_cnt_ff <= 16'h0000;
    end else if (pulse_evt) begin
      pulse_cnt_ff <= 16'(`LFM_PULSE_CYC);
    end else if (pulse_cnt_ff != 16'h0000) begin
      pulse_cnt_ff <= pulse_cnt_ff - 16'd1;
    end
  end

  assign fault_pin_o  = 1'b0;
  assign fault_pin_oe = const_sink | (pulse_cnt_ff != 16'h0000);
  // Outputs follow overtemperature and fail-safe mode; reference fault leaves them on
  assign outputs_enable = ~overtemp_in
                        & (mode_ff == LFM_NORMAL);

  // ----------------------------------------------------------------
  // Link watchdog
  // ----------------------------------------------------------------
  logic [35:0] wd_cnt_ff;
  logic        wd_kick;
  logic        wd_over;
  assign wd_kick = frame_ok & ~frame_broadcast & frame_addr_match;
  assign wd_over = (link_watchdog_period != 4'h0)
                 & (wd_cnt_ff >= 36'(link_watchdog_period * `LFM_WD_UNIT));

  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      wd_cnt_ff <= 36'h0_0000_0000;
    end else if (wd_kick | (link_watchdog_period == 4'h0)) begin
      wd_cnt_ff <= 36'h0_0000_0000;
    end else if (!wd_over) begin
      wd_cnt_ff <= wd_cnt_ff + 36'd1;
    end
  end

  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= LFM_NORMAL;
    end else begin
      case (mode_ff)
        LFM_NORMAL: begin
          if (wd_over | (stored_watchdog_period == 4'hf)) begin
            mode_ff <= failsafe_select_pin ? LFM_FS1 : LFM_FS0;
          end
        end
        LFM_FS0: mode_ff <= LFM_FS0;
        LFM_FS1: mode_ff <= LFM_FS1;
        default: mode_ff <= LFM_NORMAL;
      endcase
    end
  end

  assign failsafe_state = mode_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_clear_self: assert property (@(posedge pclk)
    disable iff (!rst_n) fault_clear_cmd |=> !fault_clear_cmd)
    else $error("clear command stuck");
  chk_low_flag: assert property (@(posedge pclk)
    disable iff (!rst_n) low_evt |=> flags_ff.low_supply && fault_pin_oe)
    else $error("low supply not reported");
  chk_pulse_len: assert property (@(posedge pclk)
    disable iff (!rst_n)
    pulse_evt |=> (pulse_cnt_ff == 16'd2000) && fault_pin_oe)
    else $error("pulse length wrong");
  chk_tsd_off: assert property (@(posedge pclk)
    disable iff (!rst_n) overtemp_in |-> !outputs_enable)
    else $error("outputs on in overtemp");
  chk_tsd_flag_hold: assert property (@(posedge pclk)
    disable iff (!rst_n)
    flags_ff.tshutdown && !fault_clear_cmd |=> flags_ff.tshutdown)
    else $error("shutdown flag lost");
  chk_ref_sink: assert property (@(posedge pclk)
    disable iff (!rst_n) ref_fault_in && !mask.mask_ref |-> fault_pin_oe)
    else $error("reference sink missing");
  chk_wd_fs: assert property (@(posedge pclk)
    disable iff (!rst_n)
    mode_ff == LFM_NORMAL && wd_over |=>
      mode_ff == ($past(failsafe_select_pin) ? LFM_FS1 : LFM_FS0))
    else $error("failsafe state wrong");
  chk_wd_off: assert property (@(posedge pclk)
    disable iff (!rst_n)
    link_watchdog_period == 4'h0 && mode_ff == LFM_NORMAL
      && stored_watchdog_period != 4'hf |=> mode_ff == LFM_NORMAL)
    else $error("disabled watchdog fired");
  chk_open_low: assert property (@(posedge pclk)
    disable iff (!rst_n)
    low_supply && !fault_clear_cmd |=> $stable(channel_open_flag))
    else $error("open seen at low supply");
  chk_diag_en: assert property (@(posedge pclk)
    disable iff (!rst_n)
    1'b1 |=> (((channel_open_flag & ~$past(channel_open_flag))
      | (channel_short_flag & ~$past(channel_short_flag)))
      & ~$past(channel_diag_enable)) == 12'h000)
    else $error("disabled channel reported");

endmodule : lfm_monitor

// >>> lfm_host_model.sv
// APB master standing in for the controller on the register bus
// Assumes pready/prdata come from the monitor on the same pclk
`timescale 1ns/1ps
`include "lfm_consts.svh"

module lfm_host_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // One transfer: setup, access until pready, then release
  // ----------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : lfm_host_model

// >>> led_driver_fault_monitor_tb.sv
// Self-checking bench for the fault monitor
// Assumes the host model drives APB; bench drives sensor inputs
`timescale 1ns/1ps
`include "lfm_consts.svh"

module led_driver_fault_monitor_tb
  import lfm_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr, pwm, opn, sht;
  logic [31:0] pwdata, prdata;
  logic [7:0]  adc;
  logic        ref_f, pre_t, ot, ext_t, f_ok, f_bc, f_am, fs_pin;
  logic [3:0]  st_wd;
  logic        fault_o, fault_oe, out_en;
  logic [1:0]  fs_st;
  int          mismatches, tests_run, n;

  lfm_host_model u_lfm_host_model (.pclk(pclk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  lfm_monitor u_lfm_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adc_supply_code(adc), .ref_fault_in(ref_f), .prethermal_in(pre_t),
    .overtemp_in(ot), .extreme_temp_in(ext_t), .frame_ok(f_ok),
    .frame_broadcast(f_bc), .frame_addr_match(f_am),
    .failsafe_select_pin(fs_pin), .stored_watchdog_period(st_wd),
    .pwm_on(pwm), .open_cmp(opn), .short_cmp(sht), .fault_pin_o(fault_o),
    .fault_pin_oe(fault_oe), .outputs_enable(out_en),
    .failsafe_state(fs_st));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    u_lfm_host_model.xfer(1'b0, a, 32'h0, q);
    chk($sformatf("reg %h", a), e, q);
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_lfm_host_model.xfer(1'b1, a, d, q);
  endtask : wr

  task automatic tick(input int c);
    repeat (c) @(posedge pclk);
  endtask : tick

  task automatic pulse(output int c);
    int w;
    w = 0;
    c = 0;
    while (fault_oe !== 1'b1 && w < 3000) begin @(negedge pclk); w++; end
    while (fault_oe === 1'b1 && c < 5000) begin @(negedge pclk); c++; end
  endtask : pulse

  task automatic clr();
    wr(`LFM_OFS_CTRL, 32'h1);
    rd(`LFM_OFS_CTRL, 32'h0);
    rd(`LFM_OFS_FLAGS, 32'h0);
  endtask : clr

  task automatic do_reset();
    presetn <= 1'b0;
    tick(2);
    presetn <= 1'b1;
  endtask : do_reset

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(`LFM_OFS_CFG, `LFM_CFG_RST);
    rd(`LFM_OFS_DIAGEN, 32'(`LFM_DIAGEN_RST));
    rd(`LFM_OFS_SUPPLY, 32'hff);
    rd(12'h020, 32'h0);
    chk("slverr", 32'h0, 32'(pslverr));
    rd(`LFM_OFS_STATUS, 32'h1);
    chk("fs state", 32'(LFM_NORMAL), 32'(fs_st));
  endtask : t_reset

  task automatic t_low();
    wr(`LFM_OFS_CFG, 32'h80);
    adc <= 8'h40;
    pulse(n);
    chk("low pulse", `LFM_PULSE_CYC, n);
    rd(`LFM_OFS_FLAGS, 32'h20);
    rd(`LFM_OFS_SUPPLY, 32'h40);
    pwm[0] <= 1'b1;
    opn[0] <= 1'b1;
    tick(300);
    rd(`LFM_OFS_OPENFLG, 32'h0);
    pwm[0] <= 1'b0;
    opn[0] <= 1'b0;
    adc <= 8'hc0;
    tick(450);
    clr();
  endtask : t_low

  task automatic t_ref();
    wr(`LFM_OFS_CFG, 32'h2_0000);
    ref_f <= 1'b1;
    tick(3);
    chk("ref masked", 32'h0, 32'(fault_oe));
    rd(`LFM_OFS_FLAGS, 32'h10);
    ref_f <= 1'b0;
    wr(`LFM_OFS_CFG, 32'h0);
    clr();
    ref_f <= 1'b1;
    tick(3000);
    chk("ref sink", 32'h1, 32'(fault_oe));
    chk("ref level", 32'h0, 32'(fault_o));
    chk("ref outen", 32'h1, 32'(out_en));
    rd(`LFM_OFS_FLAGS, 32'h11);
    ref_f <= 1'b0;
    tick(3);
    chk("ref release", 32'h0, 32'(fault_oe));
    rd(`LFM_OFS_FLAGS, 32'h11);
    clr();
  endtask : t_ref

  task automatic t_pre();
    pre_t <= 1'b1;
    pulse(n);
    chk("pre pulse", `LFM_PULSE_CYC, n);
    rd(`LFM_OFS_FLAGS, 32'h08);
    pre_t <= 1'b0;
    clr();
  endtask : t_pre

  task automatic t_tsd();
    ot <= 1'b1;
    tick(3);
    chk("tsd outen", 32'h0, 32'(out_en));
    chk("tsd sink", 32'h1, 32'(fault_oe));
    rd(`LFM_OFS_FLAGS, 32'h05);
    ot <= 1'b0;
    tick(3);
    chk("cool outen", 32'h1, 32'(out_en));
    chk("cool sink", 32'h0, 32'(fault_oe));
    rd(`LFM_OFS_FLAGS, 32'h05);
    clr();
    wr(`LFM_OFS_DIAGEN, 32'h0ff);
    wr(`LFM_OFS_CFG, 32'h80);
    ext_t <= 1'b1;
    tick(2);
    ext_t <= 1'b0;
    tick(2);
    rd(`LFM_OFS_DIAGEN, 32'(`LFM_DIAGEN_RST));
    rd(`LFM_OFS_CFG, `LFM_CFG_RST);
  endtask : t_tsd

  task automatic set_in(input bit sh, input int ch, input logic v);
    pwm[ch] <= v;
    if (sh) sht[ch] <= v;
    else opn[ch] <= v;
  endtask : set_in

  task automatic t_diag(input bit sh, input int ch, input logic [11:0] fa);
    wr(`LFM_OFS_CFG, 32'h1000);
    set_in(sh, ch, 1'b1);
    tick(100);
    set_in(sh, ch, 1'b0);
    rd(fa, 32'h0);
    set_in(sh, ch, 1'b1);
    pulse(n);
    chk("diag pulse", `LFM_PULSE_CYC, n);
    rd(fa, 32'h1 << ch);
    rd(`LFM_OFS_FLAGS, 32'h03);
    chk("diag outen", 32'h1, 32'(out_en));
    set_in(sh, ch, 1'b0);
    clr();
    rd(fa, 32'h0);
    wr(`LFM_OFS_DIAGEN, 32'hfff & ~(32'h1 << ch));
    set_in(sh, ch, 1'b1);
    tick(300);
    set_in(sh, ch, 1'b0);
    rd(fa, 32'h0);
    rd(`LFM_OFS_FLAGS, 32'h0);
    wr(`LFM_OFS_DIAGEN, 32'hfff);
  endtask : t_diag

  task automatic frame(input logic bc, input logic am);
    f_ok <= 1'b1;
    f_bc <= bc;
    f_am <= am;
    tick(1);
    f_ok <= 1'b0;
  endtask : frame

  task automatic t_stored();
    fs_pin <= 1'b0;
    st_wd <= 4'hf;
    tick(3);
    chk("stored fs", 32'(LFM_FS0), 32'(fs_st));
    rd(`LFM_OFS_STATUS, 32'h4);
    st_wd <= 4'h0;
    do_reset();
  endtask : t_stored

  task automatic t_wd();
    fs_pin <= 1'b1;
    wr(`LFM_OFS_CFG, 32'h100);
    frame(1'b0, 1'b1);
    tick(20000);
    frame(1'b1, 1'b1);
    frame(1'b0, 1'b0);
    tick(19800);
    chk("wd early", 32'(LFM_NORMAL), 32'(fs_st));
    tick(300);
    chk("wd fs", 32'(LFM_FS1), 32'(fs_st));
  endtask : t_wd

  initial begin
    mismatches = 0;
    tests_run  = 0;
    presetn = 1'b0;
    {adc, ref_f, pre_t, ot, ext_t} = {8'hc0, 4'h0};
    {f_ok, f_bc, f_am, fs_pin, st_wd} = 8'h00;
    {pwm, opn, sht} = 36'h0;
    do_reset();
    t_reset();
    t_low();
    t_ref();
    t_pre();
    t_tsd();
    t_diag(1'b0, 3, `LFM_OFS_OPENFLG);
    t_diag(1'b1, 11, `LFM_OFS_SHORTFLG);
    t_stored();
    t_wd();
    give_verdict();
  end

  initial begin
    repeat (80000) @(posedge pclk);
    mismatches++;
    give_verdict();
  end
endmodule : led_driver_fault_monitor_tb
